// File: src/rtc_trim_ctrl.sv
// Oscillator trim and temperature-compensation control with AXI4-Lite registers
//
// How it works
// - analog trim spans +32 to -31 ppm
// - code zero is +32, each step -1
// - digital trim bits 7:6, analog 5:0
// - cold coefficient register holds eight bits
// - sense enable starts sensor, converter, adjustment
// - sense enable reads zero after reset
// - sensing off uses initial trim values only
// - writing enable one runs two conversions
// - average of both conversions is stored
// - battery sensing needs its own enable
// - low battery blocks battery-mode compensation
// - battery rate ten minutes or one minute
// - digital trim codes off, +30.5, 0, -30.5
`timescale 1ns/1ps
module rtc_trim_ctrl
  import trim_pkg::*;
#(
  parameter logic [25:0] TICK_COUNT = 26'(TICK_CYCLES)  // Cycles per second tick
) (
  input  wire logic              clock,
  input  wire logic              reset_n,
  // AXI4-Lite slave
  input  wire logic [31:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [31:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Power and converter side
  input  wire logic              battery_mode,
  input  wire logic              vbat_low,
  input  wire logic              conv_done,
  input  wire logic [9:0]        conv_data,
  output logic                   conv_start,
  output logic                   sensor_on,
  // Compensation engine side
  input  wire logic [5:0]        comp_analog_trim,
  input  wire logic [1:0]        comp_digital_trim,
  output logic                   comp_active,
  output logic [7:0]             cold_coef,
  output logic [4:0]             gain,
  // Trim applied to the oscillator
  output logic [5:0]             analog_trim,
  output logic [1:0]             digital_trim,
  output logic signed [6:0]      analog_trim_ppm,
  output logic signed [7:0]      digital_trim_half_ppm,
  output logic                   digital_trim_on
);

  // ==========================================================================
  // Helper functions
  // Analog code to ppm: code 0 is +32, code 63 is -31
  function automatic logic signed [6:0] at_ppm(input logic [5:0] code);
    at_ppm = $signed(AT_TOP_PPM) - $signed({1'b0, code});
  endfunction

  // Digital code to half-ppm units; disabled and zero both give no shift
  function automatic logic signed [7:0] dt_half(input logic [1:0] code);
    unique case (code)
      DT_PLUS:  dt_half = $signed(DT_STEP_HALF);
      DT_MINUS: dt_half = -$signed(DT_STEP_HALF);
      default:  dt_half = '0;
    endcase
  endfunction

  // Byte address to register index; misaligned words never match
  function automatic logic [7:0] reg_index(input logic [31:0] addr);
    reg_index = (addr[1:0] == 2'h0 && addr[31:ADDR_BITS+2] == '0) ?
                addr[ADDR_BITS+1:2] : 8'hff;
  endfunction

  // ==========================================================================
  // Register state
  logic [7:0]  init_trim_setting;          // Digital and analog initial trim
  logic [7:0]  cold_curvature_coefficient; // Unsigned cold coefficient
  logic [7:0]  temp_sense_control_gain;    // Enables, rate and gain
  logic [9:0]  temp_result;                // Last averaged temperature
  logic [7:0]  next_init, next_cold, next_ctrl;
  logic [9:0]  next_temp;
  logic        start_write;                // Enable bit written as one

  // Bus channel state
  logic        aw_full, w_full;            // Write address and data halves held
  logic        w_lane;                     // Low byte lane enabled
  logic [7:0]  aw_idx, w_byte;
  logic        next_aw_full, next_w_full, next_w_lane;
  logic        next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [7:0]  next_aw_idx, next_w_byte;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata;

  // Block state
  logic        temp_sense_en;
  logic        batt_temp_sense_en;
  logic        batt_sense_rate;
  logic        batt_ok, sense_allowed;
  logic        batt_due, cycle_start, cycle_busy, avg_valid, conv_pulse;
  logic [9:0]  avg;

  assign temp_sense_en      = temp_sense_control_gain[TSE_BIT];
  assign batt_temp_sense_en = temp_sense_control_gain[BATT_TEMP_SENSE_EN_BIT];
  assign batt_sense_rate    = temp_sense_control_gain[RATE_BIT];

  // Battery sensing only with its enable set and the battery above lockout
  assign batt_ok       = batt_temp_sense_en && !vbat_low;
  assign sense_allowed = temp_sense_en && (!battery_mode || batt_ok);

  // ==========================================================================
  // Write path: address and data are taken in either order
  always_comb begin
    logic aw_take;
    logic w_take;
    logic do_write;
    aw_take      = s_axi_awvalid && s_axi_awready;
    w_take       = s_axi_wvalid && s_axi_wready;
    do_write     = aw_full && w_full;
    next_aw_full = aw_full;
    next_w_full  = w_full;
    next_aw_idx  = aw_idx;
    next_w_byte  = w_byte;
    next_w_lane  = w_lane;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_init    = init_trim_setting;
    next_cold    = cold_curvature_coefficient;
    next_ctrl    = temp_sense_control_gain;
    start_write  = 1'b0;
    if (aw_take) begin
      next_aw_full = 1'b1;
      next_aw_idx  = reg_index(s_axi_awaddr);
    end
    if (w_take) begin
      next_w_full = 1'b1;
      next_w_byte = s_axi_wdata[7:0];
      next_w_lane = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    // Commit once both halves are held; the answer follows a cycle later
    if (do_write) begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = RESP_OKAY;
      unique case (aw_idx)
        IDX_INIT_TRIM: begin
          if (w_lane) next_init = w_byte;
        end
        IDX_COLD_COEF: begin
          if (w_lane) next_cold = w_byte;
        end
        IDX_SENSE_CTRL: begin
          if (w_lane) begin
            next_ctrl   = w_byte;
            start_write = w_byte[TSE_BIT];
          end
        end
        IDX_TEMP_RESULT, IDX_STATUS: begin
          // Read-only: write is accepted and dropped
        end
        default: next_bresp = RESP_SLVERR;
      endcase
    end
    next_awready = !next_aw_full && !next_bvalid;
    next_wready  = !next_w_full && !next_bvalid;
  end

  // Register the write path
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      aw_full                    <= 1'b0;
      w_full                     <= 1'b0;
      aw_idx                     <= 8'h00;
      w_byte                     <= 8'h00;
      w_lane                     <= 1'b0;
      s_axi_awready              <= 1'b0;
      s_axi_wready               <= 1'b0;
      s_axi_bvalid               <= 1'b0;
      s_axi_bresp                <= RESP_OKAY;
      init_trim_setting          <= RST_INIT_TRIM;
      cold_curvature_coefficient <= RST_COLD_COEF;
      temp_sense_control_gain    <= RST_SENSE_CTRL;
    end else begin
      aw_full                    <= next_aw_full;
      w_full                     <= next_w_full;
      aw_idx                     <= next_aw_idx;
      w_byte                     <= next_w_byte;
      w_lane                     <= next_w_lane;
      s_axi_awready              <= next_awready;
      s_axi_wready               <= next_wready;
      s_axi_bvalid               <= next_bvalid;
      s_axi_bresp                <= next_bresp;
      init_trim_setting          <= next_init;
      cold_curvature_coefficient <= next_cold;
      temp_sense_control_gain    <= next_ctrl;
    end
  end

  // ==========================================================================
  // Read path: one read at a time, data registered with the valid
  always_comb begin
    next_arready = s_axi_arready;
    next_rvalid  = s_axi_rvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      next_rdata  = '0;
      unique case (reg_index(s_axi_araddr))
        IDX_INIT_TRIM:   next_rdata[7:0] = init_trim_setting;
        IDX_COLD_COEF:   next_rdata[7:0] = cold_curvature_coefficient;
        IDX_SENSE_CTRL:  next_rdata[7:0] = temp_sense_control_gain;
        IDX_TEMP_RESULT: next_rdata[9:0] = temp_result;
        IDX_STATUS: begin
          next_rdata[ST_BUSY_BIT] = cycle_busy;
          next_rdata[ST_COMP_BIT] = comp_active;
          next_rdata[ST_LOCK_BIT] = battery_mode && vbat_low;
        end
        default: next_rresp = RESP_SLVERR;
      endcase
    end
    next_arready = !next_rvalid;
  end

  // Register the read path
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
    end
  end

  // ==========================================================================
  // Conversion cycles: on an enable write, or periodically in battery mode.
  // An enable write is judged by the byte written, as the register changes only at commit
  assign cycle_start = (start_write && (!battery_mode || (w_byte[BATT_TEMP_SENSE_EN_BIT] && !vbat_low)))
                    || (sense_allowed && battery_mode && batt_due);

  batt_sense_timer #(
    .TICK_COUNT (TICK_COUNT)
  ) u_timer (
    .clock   (clock),
    .reset_n (reset_n),
    .run     (temp_sense_en && battery_mode && batt_ok),
    .fast    (batt_sense_rate),
    .due     (batt_due)
  );

  temp_cycle u_cycle (
    .clock      (clock),
    .reset_n    (reset_n),
    .start      (cycle_start),
    .conv_done  (conv_done),
    .conv_data  (conv_data),
    .conv_start (conv_pulse),
    .busy       (cycle_busy),
    .avg_valid  (avg_valid),
    .avg        (avg)
  );

  // ==========================================================================
  // Result capture and trim selection
  always_comb begin
    next_temp = avg_valid ? avg : temp_result;
  end

  // Outputs all come from flops; sensing off selects the initial trim
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      temp_result           <= RST_TEMP;
      conv_start            <= 1'b0;
      sensor_on             <= 1'b0;
      comp_active           <= 1'b0;
      cold_coef             <= RST_COLD_COEF;
      gain                  <= '0;
      analog_trim           <= RST_INIT_TRIM[AT_MSB:AT_LSB];
      digital_trim          <= RST_INIT_TRIM[DT_MSB:DT_LSB];
      analog_trim_ppm       <= at_ppm(RST_INIT_TRIM[AT_MSB:AT_LSB]);
      digital_trim_half_ppm <= dt_half(RST_INIT_TRIM[DT_MSB:DT_LSB]);
      digital_trim_on       <= 1'b0;
    end else begin
      temp_result <= next_temp;
      conv_start  <= conv_pulse;
      sensor_on   <= sense_allowed || cycle_busy;
      comp_active <= sense_allowed;
      cold_coef   <= cold_curvature_coefficient;
      gain        <= temp_sense_control_gain[GAIN_MSB:0];
      if (sense_allowed) begin
        analog_trim           <= comp_analog_trim;
        digital_trim          <= comp_digital_trim;
        analog_trim_ppm       <= at_ppm(comp_analog_trim);
        digital_trim_half_ppm <= dt_half(comp_digital_trim);
        digital_trim_on       <= (comp_digital_trim != DT_OFF);
      end else begin
        analog_trim           <= init_trim_setting[AT_MSB:AT_LSB];
        digital_trim          <= init_trim_setting[DT_MSB:DT_LSB];
        analog_trim_ppm       <= at_ppm(init_trim_setting[AT_MSB:AT_LSB]);
        digital_trim_half_ppm <= dt_half(init_trim_setting[DT_MSB:DT_LSB]);
        digital_trim_on       <= (init_trim_setting[DT_MSB:DT_LSB] != DT_OFF);
      end
    end
  end

endmodule

// File: src/trim_pkg.sv
// Package: register map, field layout, reset values and timing for the trim block
package trim_pkg;

  // ==========================================================================
  // Register indices; the bus byte address is four times the index
  localparam logic [7:0]  IDX_INIT_TRIM   = 8'h0b;  // Initial trim setting
  localparam logic [7:0]  IDX_COLD_COEF   = 8'h0c;  // Cold curvature coefficient
  localparam logic [7:0]  IDX_SENSE_CTRL  = 8'h0d;  // Sense control and gain
  localparam logic [7:0]  IDX_TEMP_RESULT = 8'h10;  // Averaged temperature, read only
  localparam logic [7:0]  IDX_STATUS      = 8'h11;  // Block status, read only
  localparam int          ADDR_BITS       = 8;      // Decoded register index width; byte address is two bits wider

  // ==========================================================================
  // Field positions
  localparam int          DT_MSB          = 7;      // Digital trim in bits 7:6
  localparam int          DT_LSB          = 6;
  localparam int          AT_MSB          = 5;      // Analog trim in bits 5:0
  localparam int          AT_LSB          = 0;
  localparam int          TSE_BIT         = 7;      // Temperature sense enable
  localparam int          BATT_TEMP_SENSE_EN_BIT        = 6;      // Battery-mode sense enable
  localparam int          RATE_BIT        = 5;      // Battery sense rate
  localparam int          GAIN_MSB        = 4;      // Gain field in bits 4:0
  localparam int          ST_BUSY_BIT     = 0;      // Status: conversion under way
  localparam int          ST_COMP_BIT     = 1;      // Status: compensation active
  localparam int          ST_LOCK_BIT     = 2;      // Status: low battery lockout

  // ==========================================================================
  // Reset values
  localparam logic [7:0]  RST_INIT_TRIM   = 8'h00;
  localparam logic [7:0]  RST_COLD_COEF   = 8'h00;
  localparam logic [7:0]  RST_SENSE_CTRL  = 8'h00;  // Sensing off after power-up
  localparam logic [9:0]  RST_TEMP        = 10'h000;

  // ==========================================================================
  // Trim arithmetic constants
  localparam logic [6:0]  AT_TOP_PPM      = 7'h20;  // Code zero means +32 ppm
  localparam logic [7:0]  DT_STEP_HALF    = 8'h3d;  // 30.5 ppm in half-ppm units
  localparam logic [1:0]  DT_OFF          = 2'h0;
  localparam logic [1:0]  DT_PLUS         = 2'h1;
  localparam logic [1:0]  DT_ZERO         = 2'h2;
  localparam logic [1:0]  DT_MINUS        = 2'h3;

  // ==========================================================================
  // Bus answers
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // ==========================================================================
  // Timing
  localparam longint      CLK_HZ          = 50_000_000;  // System clock rate
  localparam longint      TICK_S          = 1;           // Prescaler tick, seconds
  localparam longint      TICK_CYCLES     = TICK_S * CLK_HZ;
  localparam int          SEC_PER_MIN     = 60;
  localparam int          SLOW_PERIOD_MIN = 10;          // Rate bit clear
  localparam int          FAST_PERIOD_MIN = 1;           // Rate bit set
  localparam logic [9:0]  SLOW_PERIOD_S   = 10'(SLOW_PERIOD_MIN * SEC_PER_MIN);
  localparam logic [9:0]  FAST_PERIOD_S   = 10'(FAST_PERIOD_MIN * SEC_PER_MIN);

  // Conversion sequencer states
  typedef enum logic [1:0] {IDLE, FIRST, SECOND} cycle_state_t;

endpackage

// File: src/batt_sense_timer.sv
// Battery-mode sensing period timer built from a one-second enable divider
`timescale 1ns/1ps
module batt_sense_timer
  import trim_pkg::*;
#(
  parameter logic [25:0] TICK_COUNT = 26'(TICK_CYCLES)  // Cycles per second tick
) (
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic run,      // Battery sensing allowed
  input  wire logic fast,     // Rate bit: one minute instead of ten
  output logic      due       // One-cycle pulse when a cycle is due
);

  // ==========================================================================
  // State
  logic [25:0] div;           // Cycle divider
  logic [9:0]  secs;          // Seconds into the period
  logic        next_due;
  logic [25:0] next_div;
  logic [9:0]  next_secs;

  // ==========================================================================
  // Next values; the period restarts whenever running stops
  always_comb begin
    logic [9:0] period;
    period    = fast ? FAST_PERIOD_S : SLOW_PERIOD_S;
    next_div  = div;
    next_secs = secs;
    next_due  = 1'b0;
    if (!run) begin
      next_div  = '0;
      next_secs = '0;
    end else if (div == TICK_COUNT - 26'h1) begin
      next_div = '0;
      // A rate change mid-period applies at the next second tick; a count past the new period wraps then
      if (secs >= period - 10'h1) begin
        next_secs = '0;
        next_due  = 1'b1;
      end else begin
        next_secs = secs + 10'h1;
      end
    end else begin
      next_div = div + 26'h1;
    end
  end

  // Register
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      div  <= '0;
      secs <= '0;
      due  <= 1'b0;
    end else begin
      div  <= next_div;
      secs <= next_secs;
      due  <= next_due;
    end
  end

endmodule

// File: src/temp_cycle.sv
// Two-conversion temperature cycle sequencer with averaging
`timescale 1ns/1ps
module temp_cycle
  import trim_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic       start,       // Begin a cycle; ignored while busy
  input  wire logic       conv_done,   // Converter finished, data valid
  input  wire logic [9:0] conv_data,   // Converter result
  output logic            conv_start,  // One-cycle pulse to the converter
  output logic            busy,        // Cycle under way
  output logic            avg_valid,   // One-cycle pulse with a new average
  output logic [9:0]      avg          // Average of the two conversions
);

  // ==========================================================================
  // State
  cycle_state_t state;
  cycle_state_t next_state;
  logic [9:0]   first;                 // First conversion held for averaging
  logic [9:0]   next_first;
  logic [9:0]   next_avg;
  logic         next_conv_start;
  logic         next_avg_valid;

  // ==========================================================================
  // Next values
  always_comb begin
    logic [10:0] sum;
    sum             = {1'b0, first} + {1'b0, conv_data};
    next_state      = state;
    next_first      = first;
    next_avg        = avg;
    next_conv_start = 1'b0;
    next_avg_valid  = 1'b0;
    unique case (state)
      IDLE: begin
        if (start) begin
          next_state      = FIRST;
          next_conv_start = 1'b1;
        end
      end
      FIRST: begin
        if (conv_done) begin
          next_first      = conv_data;
          next_state      = SECOND;
          next_conv_start = 1'b1;
        end
      end
      SECOND: begin
        // Truncating average; drops the half degree of the LSB
        if (conv_done) begin
          next_avg       = sum[10:1];
          next_avg_valid = 1'b1;
          next_state     = IDLE;
        end
      end
    endcase
  end

  // Register
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state      <= IDLE;
      first      <= RST_TEMP;
      avg        <= RST_TEMP;
      conv_start <= 1'b0;
      avg_valid  <= 1'b0;
      busy       <= 1'b0;
    end else begin
      state      <= next_state;
      first      <= next_first;
      avg        <= next_avg;
      conv_start <= next_conv_start;
      avg_valid  <= next_avg_valid;
      busy       <= (next_state != IDLE);
    end
  end

endmodule

// File: test/trim_chk.sv
// Port-level assertions for the trim control block
`timescale 1ns/1ps
module trim_chk (
  input wire logic              clock, reset_n, conv_start, comp_active, battery_mode,
  input wire logic              vbat_low, digital_trim_on, s_axi_awvalid, s_axi_awready,
  input wire logic              s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_arvalid,
  input wire logic              s_axi_arready, s_axi_rvalid,
  input wire logic [1:0]        digital_trim,
  input wire logic [5:0]        analog_trim, comp_analog_trim,
  input wire logic signed [6:0] analog_trim_ppm,
  input wire logic signed [7:0] digital_trim_half_ppm
);
  // ==========================================================================
  // One clock domain, so clocking and reset are given once
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  property p_at_ppm; analog_trim_ppm == 7'h20 - $signed({1'b0, analog_trim}); endproperty
  a_at_ppm: assert property (p_at_ppm) else $error("analog ppm wrong");
  property p_dt; digital_trim_on == (digital_trim != 2'h0) && digital_trim_half_ppm ==
    (digital_trim == 2'h1 ? 8'h3d : digital_trim == 2'h3 ? 8'hc3 : 8'h00); endproperty
  a_dt: assert property (p_dt) else $error("digital trim wrong");
  // Constant engine analog trim must reach the oscillator once sensing has settled
  property p_comp; comp_active [*3] |-> analog_trim == $past(comp_analog_trim); endproperty
  a_comp: assert property (p_comp) else $error("trim not from engine");
  property p_lock; (battery_mode && vbat_low) [*3] |-> !comp_active; endproperty
  a_lock: assert property (p_lock) else $error("low battery active");
  property p_pulse; conv_start |=> !conv_start; endproperty
  a_pulse: assert property (p_pulse) else $error("start too long");
  property p_rst; $rose(reset_n) |-> !comp_active && !conv_start; endproperty
  a_rst: assert property (p_rst) else $error("active after reset");
  property p_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid; endproperty
  a_wr: assert property (p_wr) else $error("write answer late");
  property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
endmodule
bind rtc_trim_ctrl trim_chk trim_chk_inst (.*);

// File: test/conv_model.sv
// Temperature converter stand-in with short or long conversion time
`timescale 1ns/1ps
module conv_model (
  input  wire logic       clock,
  input  wire logic       conv_start,
  input  wire logic       slow,                  // Long conversion when high
  input  wire logic [9:0] seed,                  // First result; second is seed + 7
  output logic            conv_done = 1'b0,
  output logic [9:0]      conv_data = 10'h155
);
  int   wait_n = -1;     // Cycles to the answer, -1 when idle
  logic second = 1'b0;   // Next answer closes a pair
  // Data toggles outside the done cycle so a stale sample never looks valid
  always @(posedge clock) begin
    conv_done <= 1'b0;
    conv_data <= ~conv_data;
    if (conv_start) wait_n <= slow ? 9 : 1;
    else if (wait_n > 0) wait_n <= wait_n - 1;
    else if (wait_n == 0) begin
      wait_n    <= -1;
      conv_done <= 1'b1;
      conv_data <= second ? seed + 10'h007 : seed;
      second    <= ~second;
    end
  end
endmodule

// File: test/tb_top.sv
// Self-checking bench for the trim control block
`timescale 1ns/1ps
module tb_top;
  import trim_pkg::*;
  logic clock = 0, reset_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1;
  logic s_axi_arvalid = 0, s_axi_rready = 1, battery_mode = 0, vbat_low = 0, slow = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, conv_done;
  logic conv_start, sensor_on, comp_active, digital_trim_on;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp, digital_trim, comp_digital_trim = 2'h3;
  logic [5:0]  analog_trim, comp_analog_trim = 6'h15;
  logic [7:0]  cold_coef;
  logic [4:0]  gain;
  logic [9:0]  conv_data, seed = 10'h120;
  logic signed [6:0] analog_trim_ppm;
  logic signed [7:0] digital_trim_half_ppm;
  int fails = 0, samples_checked = 0, starts = 0, snap;
  // Trim settings beside the ppm figures they must give, every digital code once
  // Code 0x3f, the lowest, is set in the second row, soon after start-up
  typedef struct {logic [7:0] v; logic [6:0] ppm; logic [7:0] half;} row_t;
  row_t rows[4] = '{'{8'h00, 7'h20, 8'h00}, '{8'h7f, 7'h61, 8'h3d},
                    '{8'ha0, 7'h00, 8'h00}, '{8'hc1, 7'h1f, 8'hc3}};
  rtc_trim_ctrl #(.TICK_COUNT(26'h000a)) rtc_trim_ctrl_inst (.*);
  conv_model conv_model_inst (.*);
  always #10 clock = ~clock;
  always @(posedge clock) if (conv_start === 1'b1) starts <= starts + 1;
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Ready and answer channels stay open, so each wait ends at the answer edge
  task automatic wr(input logic [7:0] i, d);
    s_axi_awaddr <= {22'h0, i, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
  endtask
  task automatic rd_reg(input logic [7:0] i);
    s_axi_araddr <= {22'h0, i, 2'h0};
    s_axi_arvalid <= 1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
  endtask
  task automatic give_verdict;
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (8000) @(posedge clock);
    fails++;
    give_verdict;
  end
  initial begin
    repeat (4) @(posedge clock);
    reset_n <= 1;
    @(posedge clock);
    for (int i = 0; i < 3; i++) begin
      rd_reg(IDX_INIT_TRIM + 8'(i));
      chk("reset", rd, 0);
    end
    rd_reg(8'h40);
    chk("unmapped", 32'(resp), 32'(RESP_SLVERR));
    foreach (rows[i]) begin
      wr(IDX_INIT_TRIM, rows[i].v);
      rd_reg(IDX_INIT_TRIM);
      chk("readback", rd, 32'(rows[i].v));
      chk("analog", 32'(analog_trim), 32'(rows[i].v[5:0]));
      chk("digital", 32'(digital_trim), 32'(rows[i].v[7:6]));
      chk("ppm", {25'h0, analog_trim_ppm}, 32'(rows[i].ppm));
      chk("half", {24'h0, digital_trim_half_ppm}, 32'(rows[i].half));
    end
    // 0x46 is a mid-range coefficient
    wr(IDX_COLD_COEF, 8'h46);
    rd_reg(IDX_COLD_COEF);
    chk("coef", rd, 32'h0000_0046);
    chk("coef out", 32'(cold_coef), 32'h0000_0046);
    wr(IDX_SENSE_CTRL, 8'h08);
    // Fast then slow converter; each enable write must run exactly one pair
    for (int k = 0; k < 2; k++) begin
      snap = starts;
      wr(IDX_SENSE_CTRL, 8'h88);
      for (int n = 0; n < 40; n++) begin
        rd_reg(IDX_STATUS);
        if (rd[ST_BUSY_BIT] === 1'b0) break;
      end
      rd_reg(IDX_TEMP_RESULT);
      chk("temp", rd, {22'h0, seed + 10'h003});
      chk("starts", starts - snap, 2);
      slow <= 1;
      seed <= 10'h2f0;
    end
    chk("gain", 32'(gain), 32'h0000_0008);
    chk("active", 32'(comp_active), 1);
    chk("sensor", 32'(sensor_on), 1);
    chk("applied", 32'(analog_trim), 32'(comp_analog_trim));
    battery_mode <= 1;
    repeat (3) @(posedge clock);
    chk("batt off", 32'(comp_active), 0);
    chk("sensor off", 32'(sensor_on), 0);
    snap = starts;
    wr(IDX_SENSE_CTRL, 8'he8);
    repeat (650) @(posedge clock);
    chk("fast rate", starts - snap, 4);
    snap = starts;
    wr(IDX_SENSE_CTRL, 8'hc8);
    repeat (650) @(posedge clock);
    chk("slow rate", starts - snap, 2);
    vbat_low <= 1;
    repeat (4) @(posedge clock);
    chk("lockout", 32'(comp_active), 0);
    snap = starts;
    wr(IDX_SENSE_CTRL, 8'hc8);
    rd_reg(IDX_STATUS);
    chk("lock flag", 32'(rd[ST_LOCK_BIT]), 1);
    repeat (30) @(posedge clock);
    chk("no start", starts - snap, 0);
    give_verdict;
  end
endmodule
